// >>> core/ucr_consts.svh
`ifndef UCR_CONSTS_SVH
`define UCR_CONSTS_SVH
// Notes on behaviour
// - When a tone first appears, wait 23 ms for reflections to die away.
// - Then count the tone over a 23 ms window and act on that channel.
// - Any period below 18 us or above 36 us restarts reception.
// - Command 2 mutes volume; a later command other than volume up or down unmutes it.
// - Volume up and down are ignored while muted.
// - Command 1 toggles power, or in the other variant only turns it off.
// - Power command acts only after being present for 0.7 s.
// - Power comes up in the off state.
// - While off, analog levels do not change.
// - While off, a program channel held 0.7 s turns power on.
// - A bus line asserted for at least 10 us is a local command.
// - After acceptance wait 46.2 ms, then pulse the bus for 23.1 ms.
// - During the pulse the code lines are actively driven low.
// - A local command wins over a simultaneous remote one.
// - Bus code is channel plus one, negative logic, E weight 1, A..D 2..16.
// - Channel roles: power, mute, colour, normalise, brightness, volume, programs 15-30.
// - Each analog step takes 184.8 ms while up or down is held.
// - Each analog output is PWM with 30 duty levels.
// - Normalise sets the analog levels to mid-range.
// - All codes appear on the five-line bus, also used for local input; a code that arrives while a pulse is pending is not sent.

`define UCR_CLK_HZ       25000000
`define UCR_CLK_MHZ      25
`define UCR_T_SETTLE_US  23000
`define UCR_T_MEAS_US    23000
`define UCR_T_PER_MIN_US 18
`define UCR_T_PER_MAX_US 36
`define UCR_T_HOLD_MS    700
`define UCR_T_LOCAL_US   10
`define UCR_T_PROC_US    46200
`define UCR_T_PULSE_US   23100
`define UCR_T_STEP_US    184800
`define UCR_PWM_HZ       8990

`define UCR_SETTLE_CYC  (`UCR_T_SETTLE_US * `UCR_CLK_MHZ)
`define UCR_MEAS_CYC    (`UCR_T_MEAS_US * `UCR_CLK_MHZ)
`define UCR_PER_MIN_CYC ((`UCR_T_PER_MIN_US * `UCR_CLK_HZ + 999999) / 1000000)
`define UCR_PER_MAX_CYC ((`UCR_T_PER_MAX_US * `UCR_CLK_HZ) / 1000000)
`define UCR_HOLD_CYC    (`UCR_T_HOLD_MS * (`UCR_CLK_HZ / 1000))
`define UCR_LOCAL_CYC   ((`UCR_T_LOCAL_US * `UCR_CLK_HZ + 999999) / 1000000)
`define UCR_PROC_CYC    (`UCR_T_PROC_US * `UCR_CLK_MHZ)
`define UCR_PULSE_CYC   (`UCR_T_PULSE_US * `UCR_CLK_MHZ)
`define UCR_STEP_CYC    (`UCR_T_STEP_US * `UCR_CLK_MHZ)
`define UCR_LVL_STEPS   30
`define UCR_PWM_DIV     (`UCR_CLK_HZ / (`UCR_PWM_HZ * `UCR_LVL_STEPS))

// Tone of channel 1 and channel spacing, in tenths of a hertz.
`define UCR_F1_DHZ      339449
`define UCR_FSTEP_DHZ   3464

`define UCR_LVL_MIN     5'h01
`define UCR_LVL_MAX     5'h1E
`define UCR_LVL_MID     5'h0F

`define UCR_CH_NONE     5'h00
`define UCR_CH_ONOFF    5'h01
`define UCR_CH_MUTE     5'h02
`define UCR_CH_COL_UP   5'h03
`define UCR_CH_NORM     5'h04
`define UCR_CH_COL_DN   5'h05
`define UCR_CH_BRI_UP   5'h07
`define UCR_CH_BRI_DN   5'h09
`define UCR_CH_VOL_UP   5'h0B
`define UCR_CH_VOL_DN   5'h0D
`define UCR_CH_PROG_LO  5'h0F
`define UCR_CH_PROG_HI  5'h1E

`define UCR_A_CTRL      8'h00
`define UCR_A_STATUS    8'h04
`define UCR_A_LEVELS    8'h08
`define UCR_CTRL_TOGGLE 0
`define UCR_CTRL_RST    32'h0000_0001
`endif

// >>> core/ucr_pkg.sv
package ucr_pkg;
   typedef enum logic [1:0] {
      RX_IDLE   = 2'b00,
      RX_SETTLE = 2'b01,
      RX_MEAS   = 2'b10
   } ucr_rx_e;
   typedef enum logic [1:0] {
      BUS_IDLE  = 2'b00,
      BUS_PROC  = 2'b01,
      BUS_PULSE = 2'b10
   } ucr_bus_e;
   typedef logic [4:0] ucr_ch_t;
endpackage

// >>> core/ucr_filt.sv
`timescale 1ns/100ps
// Two-stage synchroniser followed by a stability filter: the output takes
// the input value only after it has held still for N clocks.
module ucr_filt #(
   parameter int W = 5,
   parameter int N = 250
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] din,
   input  wire logic         clr,
   output logic      [W-1:0] dout,
   output logic              armed
);
   localparam int CW = $clog2(N + 1);
   logic [W-1:0]  s1_q, s2_q, s3_q, out_q, out_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic          arm_q, arm_d;

   generate
      if (N < 1 || W < 1) begin : g_bad
         $error("ucr_filt needs N and W of at least one");
      end
   endgenerate

   always_comb begin
      cnt_d = cnt_q;
      out_d = out_q;
      arm_d = arm_q;
      if (clr) begin
         cnt_d = '0;
         out_d = '0;
         arm_d = 1'b0;
      end else if (s2_q != s3_q) begin
         cnt_d = '0;
      end else if (cnt_q == CW'(N - 1)) begin
         out_d = s3_q;
         arm_d = 1'b1;
      end else begin
         cnt_d = cnt_q + CW'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         out_q <= '0;
         cnt_q <= '0;
         arm_q <= 1'b0;
      end else begin
         s1_q  <= din;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         out_q <= out_d;
         cnt_q <= cnt_d;
         arm_q <= arm_d;
      end
   end

   assign dout  = out_q;
   assign armed = arm_q;
endmodule // ucr_filt

// >>> core/ucr_level.sv
`timescale 1ns/100ps
`include "ucr_consts.svh"
// One analog channel: a stepped level and its PWM output.
module ucr_level #(
   parameter int STEP = `UCR_STEP_CYC,
   parameter int DIV  = `UCR_PWM_DIV
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       up,
   input  wire logic       down,
   input  wire logic       norm,
   input  wire logic       freeze,
   input  wire logic       blank,
   output logic      [4:0] level,
   output logic            pwm
);
   logic [31:0] stp_q, stp_d, div_q, div_d;
   logic [4:0]  lvl_q, lvl_d, slot_q, slot_d;
   logic        pwm_q, pwm_d;

   generate
      if (STEP < 1 || DIV < 1) begin : g_bad
         $error("ucr_level needs STEP and DIV of at least one");
      end
   endgenerate

   always_comb begin
      lvl_d = lvl_q;
      stp_d = '0;
      if (!freeze) begin
         if (norm) begin
            lvl_d = `UCR_LVL_MID;
         end else if (up ^ down) begin
            stp_d = stp_q + 32'h1;
            if (stp_q == 32'(STEP - 1)) begin
               stp_d = '0;
               if (up && lvl_q != `UCR_LVL_MAX) lvl_d = lvl_q + 5'h01;
               if (down && lvl_q != `UCR_LVL_MIN) lvl_d = lvl_q - 5'h01;
            end
         end
      end
      div_d  = (div_q == 32'(DIV - 1)) ? 32'h0 : div_q + 32'h1;
      slot_d = slot_q;
      if (div_q == 32'(DIV - 1))
         slot_d = (slot_q == `UCR_LVL_MAX - 5'h01) ? 5'h00 : slot_q + 5'h01;
      pwm_d = !blank && (slot_q < lvl_q);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_q  <= `UCR_LVL_MID;
         stp_q  <= '0;
         div_q  <= '0;
         slot_q <= '0;
         pwm_q  <= 1'b0;
      end else begin
         lvl_q  <= lvl_d;
         stp_q  <= stp_d;
         div_q  <= div_d;
         slot_q <= slot_d;
         pwm_q  <= pwm_d;
      end
   end

   assign level = lvl_q;
   assign pwm   = pwm_q;
endmodule // ucr_level

// >>> core/ucr_receiver.sv
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps
`include "ucr_consts.svh"
module ucr_receiver #(
   parameter int SETTLE_CYC = `UCR_SETTLE_CYC,
   parameter int MEAS_CYC   = `UCR_MEAS_CYC,
   parameter int HOLD_CYC   = `UCR_HOLD_CYC,
   parameter int PROC_CYC   = `UCR_PROC_CYC,
   parameter int PULSE_CYC  = `UCR_PULSE_CYC,
   parameter int STEP_CYC   = `UCR_STEP_CYC,
   parameter int PWM_DIV    = `UCR_PWM_DIV
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        us_in,
   input  wire logic [4:0]  bus_in,
   output logic      [4:0]  bus_out,
   output logic      [4:0]  bus_oe,
   output logic             power_on,
   output logic             vol_pwm,
   output logic             color_pwm,
   output logic             bright_pwm
);
   // ----------------------------------------------------------------------
   // Parameter checks and declarations
   // ----------------------------------------------------------------------
   generate
      if (SETTLE_CYC < 1 || MEAS_CYC < 1 || HOLD_CYC < 1 || PROC_CYC < 1 ||
          PULSE_CYC < 1 || MEAS_CYC > 60000000) begin : g_bad
         $error("ucr_receiver timing parameters out of range");
      end
   endgenerate

   localparam logic [15:0] PER_MIN = 16'(`UCR_PER_MIN_CYC);
   localparam logic [15:0] PER_MAX = 16'(`UCR_PER_MAX_CYC);

   ucr_pkg::ucr_rx_e  rx_q, rx_d;
   ucr_pkg::ucr_bus_e bs_q, bs_d;
   ucr_pkg::ucr_ch_t  rxch_q, rxch_d, loch_q, loch_d, prev_q, cmd_now;
   logic [31:0] tmr_q, tmr_d, btmr_q, btmr_d, hold_q, hold_d;
   logic [15:0] per_q, per_d, edg_q, edg_d;
   logic [4:0]  bcode_q, bcode_d, oe_q, oe_d, loc_code, vol_l, col_l, bri_l;
   logic        us_s, us_p_q, rise, loc_armed, loc_blind, drive;
   logic        new_cmd, hold_hit, on_q, on_d, mute_q, mute_d, tog_q, tog_d;
   logic [31:0] rd_q, rd_d;
   logic        hit;

   // ----------------------------------------------------------------------
   // Input conditioning
   // ----------------------------------------------------------------------
   ucr_filt #(.W(1), .N(1)) u_us (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (us_in),
      .clr     (1'b0),
      .dout    (us_s),
      .armed   ()
   );

   // Our own pulse reads back on the lines, so the filter is held clear
   // while we drive and must re-qualify a key after we let go.
   ucr_filt #(.W(5), .N(`UCR_LOCAL_CYC)) u_loc (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (bus_in),
      .clr     (drive),
      .dout    (loc_code),
      .armed   (loc_armed)
   );

   assign rise      = us_s && !us_p_q;
   assign loc_blind = drive || !loc_armed;
   assign drive     = (bs_q == ucr_pkg::BUS_PULSE);

   // ----------------------------------------------------------------------
   // Tone measurement
   // ----------------------------------------------------------------------
   // Rising edges in one window are compared with thresholds half a
   // channel below each tone; anything above channel 30 is no channel.
   function automatic ucr_pkg::ucr_ch_t decode(input logic [15:0] n);
      ucr_pkg::ucr_ch_t ch;
      longint           thr;
      ch = `UCR_CH_NONE;
      for (int c = 1; c <= 31; c++) begin
         thr = ((longint'(`UCR_F1_DHZ) + longint'(`UCR_FSTEP_DHZ) * (c - 1)
               - longint'(`UCR_FSTEP_DHZ) / 2) * MEAS_CYC) / (longint'(`UCR_CLK_HZ) * 10);
         if (longint'(n) >= thr) ch = (c == 31) ? `UCR_CH_NONE : 5'(c);
      end
      return ch;
   endfunction

   always_comb begin
      rx_d   = rx_q;
      tmr_d  = tmr_q + 32'h1;
      per_d  = (per_q == 16'hFFFF) ? per_q : per_q + 16'h1;
      edg_d  = edg_q;
      rxch_d = rxch_q;
      if (rise) per_d = 16'h1;
      case (rx_q)
         ucr_pkg::RX_IDLE: begin
            tmr_d  = '0;
            rxch_d = `UCR_CH_NONE;
            if (rise) rx_d = ucr_pkg::RX_SETTLE;
         end
         ucr_pkg::RX_SETTLE: begin
            if (tmr_q == 32'(SETTLE_CYC - 1)) begin
               rx_d  = ucr_pkg::RX_MEAS;
               tmr_d = '0;
               edg_d = '0;
            end
         end
         ucr_pkg::RX_MEAS: begin
            if (rise && edg_q != 16'hFFFF) edg_d = edg_q + 16'h1;
            if (tmr_q == 32'(MEAS_CYC - 1)) begin
               rxch_d = decode(edg_d);
               tmr_d  = '0;
               edg_d  = '0;
            end
         end
         default: rx_d = ucr_pkg::RX_IDLE;
      endcase
      // Loss of tone shows up as an over-long period and also ends reception.
      if (rx_q != ucr_pkg::RX_IDLE &&
          ((rise && per_q < PER_MIN) || per_q > PER_MAX)) begin
         rx_d   = ucr_pkg::RX_IDLE;
         rxch_d = `UCR_CH_NONE;
         tmr_d  = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_q   <= ucr_pkg::RX_IDLE;
         tmr_q  <= '0;
         per_q  <= '0;
         edg_q  <= '0;
         rxch_q <= `UCR_CH_NONE;
         us_p_q <= 1'b0;
      end else begin
         rx_q   <= rx_d;
         tmr_q  <= tmr_d;
         per_q  <= per_d;
         edg_q  <= edg_d;
         rxch_q <= rxch_d;
         us_p_q <= us_s;
      end
   end

   // ----------------------------------------------------------------------
   // Command selection and hold timing
   // ----------------------------------------------------------------------
   always_comb begin
      loch_d = loch_q;
      if (!loc_blind)
         loch_d = (loc_code >= 5'h02) ? loc_code - 5'h01 : `UCR_CH_NONE;
   end

   assign cmd_now  = (loch_q != `UCR_CH_NONE) ? loch_q : rxch_q;
   assign new_cmd  = (cmd_now != `UCR_CH_NONE) && (cmd_now != prev_q);
   assign hold_hit = (cmd_now != `UCR_CH_NONE) && (cmd_now == prev_q) &&
                     (hold_q == 32'(HOLD_CYC - 1));

   always_comb begin
      hold_d = '0;
      if (cmd_now != `UCR_CH_NONE && cmd_now == prev_q)
         hold_d = (hold_q == 32'(HOLD_CYC)) ? hold_q : hold_q + 32'h1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loch_q <= `UCR_CH_NONE;
         prev_q <= `UCR_CH_NONE;
         hold_q <= '0;
      end else begin
         loch_q <= loch_d;
         prev_q <= cmd_now;
         hold_q <= hold_d;
      end
   end

   // ----------------------------------------------------------------------
   // Bus answer: processing delay then a low pulse on the code lines
   // ----------------------------------------------------------------------
   // Commands that arrive while a pulse is pending still act on the set but
   // produce no second pulse.
   always_comb begin
      bs_d    = bs_q;
      btmr_d  = btmr_q + 32'h1;
      bcode_d = bcode_q;
      oe_d    = 5'h00;
      case (bs_q)
         ucr_pkg::BUS_IDLE: begin
            btmr_d = '0;
            if (new_cmd) begin
               bs_d    = ucr_pkg::BUS_PROC;
               bcode_d = cmd_now + 5'h01;
            end
         end
         ucr_pkg::BUS_PROC: begin
            if (btmr_q == 32'(PROC_CYC - 1)) begin
               bs_d   = ucr_pkg::BUS_PULSE;
               btmr_d = '0;
               oe_d   = bcode_q;
            end
         end
         ucr_pkg::BUS_PULSE: begin
            oe_d = bcode_q;
            if (btmr_q == 32'(PULSE_CYC - 1)) begin
               bs_d   = ucr_pkg::BUS_IDLE;
               btmr_d = '0;
               oe_d   = 5'h00;
            end
         end
         default: bs_d = ucr_pkg::BUS_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bs_q    <= ucr_pkg::BUS_IDLE;
         btmr_q  <= '0;
         bcode_q <= 5'h00;
         oe_q    <= 5'h00;
      end else begin
         bs_q    <= bs_d;
         btmr_q  <= btmr_d;
         bcode_q <= bcode_d;
         oe_q    <= oe_d;
      end
   end

   assign bus_oe  = oe_q;
   assign bus_out = 5'h00;

   // ----------------------------------------------------------------------
   // Power and mute state
   // ----------------------------------------------------------------------
   always_comb begin
      on_d   = on_q;
      mute_d = mute_q;
      if (hold_hit && cmd_now == `UCR_CH_ONOFF)
         on_d = tog_q ? !on_q : 1'b0;
      else if (hold_hit && !on_q && cmd_now >= `UCR_CH_PROG_LO &&
               cmd_now <= `UCR_CH_PROG_HI)
         on_d = 1'b1;
      if (new_cmd) begin
         if (cmd_now == `UCR_CH_MUTE) mute_d = !mute_q;
         else if (cmd_now != `UCR_CH_VOL_UP && cmd_now != `UCR_CH_VOL_DN)
            mute_d = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_q   <= 1'b0;
         mute_q <= 1'b0;
      end else begin
         on_q   <= on_d;
         mute_q <= mute_d;
      end
   end

   assign power_on = on_q;

   // ----------------------------------------------------------------------
   // Analog channels
   // ----------------------------------------------------------------------
   ucr_level #(.STEP(STEP_CYC), .DIV(PWM_DIV)) u_vol (
      .pclk    (pclk),
      .presetn (presetn),
      .up      (cmd_now == `UCR_CH_VOL_UP && !mute_q),
      .down    (cmd_now == `UCR_CH_VOL_DN && !mute_q),
      .norm    (new_cmd && cmd_now == `UCR_CH_NORM),
      .freeze  (!on_q),
      .blank   (mute_q),
      .level   (vol_l),
      .pwm     (vol_pwm)
   );

   ucr_level #(.STEP(STEP_CYC), .DIV(PWM_DIV)) u_col (
      .pclk    (pclk),
      .presetn (presetn),
      .up      (cmd_now == `UCR_CH_COL_UP),
      .down    (cmd_now == `UCR_CH_COL_DN),
      .norm    (new_cmd && cmd_now == `UCR_CH_NORM),
      .freeze  (!on_q),
      .blank   (1'b0),
      .level   (col_l),
      .pwm     (color_pwm)
   );

   ucr_level #(.STEP(STEP_CYC), .DIV(PWM_DIV)) u_bri (
      .pclk    (pclk),
      .presetn (presetn),
      .up      (cmd_now == `UCR_CH_BRI_UP),
      .down    (cmd_now == `UCR_CH_BRI_DN),
      .norm    (new_cmd && cmd_now == `UCR_CH_NORM),
      .freeze  (!on_q),
      .blank   (1'b0),
      .level   (bri_l),
      .pwm     (bright_pwm)
   );

   // ----------------------------------------------------------------------
   // APB register file
   // ----------------------------------------------------------------------
   assign hit     = (paddr == `UCR_A_CTRL) || (paddr == `UCR_A_STATUS) ||
                    (paddr == `UCR_A_LEVELS);
   assign pready  = psel && penable;
   assign pslverr = psel && penable && !hit;
   assign prdata  = rd_q;

   // Read data is captured in the setup cycle so that it comes from a flop.
   always_comb begin
      tog_d = tog_q;
      rd_d  = rd_q;
      if (psel && penable && pwrite && paddr == `UCR_A_CTRL)
         tog_d = pwdata[`UCR_CTRL_TOGGLE];
      if (psel && !penable) begin
         case (paddr)
            `UCR_A_CTRL:   rd_d = {31'h0, tog_q};
            `UCR_A_STATUS: rd_d = {17'h0, bcode_q, 1'b0, drive,
                                   rx_q != ucr_pkg::RX_IDLE, cmd_now, mute_q, on_q};
            `UCR_A_LEVELS: rd_d = {11'h0, bri_l, 3'h0, col_l, 3'h0, vol_l};
            default:       rd_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tog_q <= 1'(`UCR_CTRL_RST);
         rd_q  <= 32'h0;
      end else begin
         tog_q <= tog_d;
         rd_q  <= rd_d;
      end
   end
endmodule // ucr_receiver

// >>> bench/ucr_receiver_sva.sv
`timescale 1ns/100ps
// ----------
// Command bus and register port checks.
// ----------
module ucr_receiver_sva #(
   parameter int PROC_CYC  = 300,
   parameter int PULSE_CYC = 200
) (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire logic [4:0] bus_out,
   input wire logic [4:0] bus_oe,
   input wire logic       power_on
);
   logic [15:0] on_q, on_d, off_q, off_d;
   // The quiet counter saturates so a long idle spell cannot wrap into a false gap.
   always_comb begin
      on_d = (|bus_oe) ? on_q + 16'h0001 : 16'h0000;
      off_d = (|bus_oe) ? 16'h0000 : off_q + {15'h0000, ~&off_q};
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_q <= 16'h0000;
         off_q <= 16'h0000;
      end else begin
         on_q <= on_d;
         off_q <= off_d;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_rise; $rose(|bus_oe); endsequence
   sequence s_fall; $fell(|bus_oe); endsequence
   AST_READY: assert property (psel && penable |-> pready)
      else $error("no ready");
   AST_SLVERR: assert property (pslverr |-> psel && penable)
      else $error("stray error");
   AST_DRIVE_LOW: assert property ((|bus_oe) |-> bus_out == 5'h00)
      else $error("bus driven high");
   AST_CODE_MIN: assert property ((|bus_oe) |-> bus_oe >= 5'h02)
      else $error("bad code");
   AST_CODE_HOLD: assert property ((|bus_oe) ##1 (|bus_oe) |-> $stable(bus_oe))
      else $error("code moved");
   AST_PULSE_LEN: assert property (s_fall |-> on_q == 16'(PULSE_CYC))
      else $error("pulse length");
   AST_PROC_WAIT: assert property (s_rise |-> off_q >= 16'(PROC_CYC))
      else $error("pulse too soon");
   AST_POWERUP_OFF: assert property (!$past(presetn) |-> !power_on && bus_oe == 5'h00)
      else $error("not off");
endmodule // ucr_receiver_sva

// >>> bench/ucr_partner.sv
`timescale 1ns/100ps
// ----------
// Tone amplifier and local keyboard.
// ----------
module ucr_partner (
   input  wire logic        pclk,
   input  wire logic [15:0] tone_per,
   input  wire logic [4:0]  key,
   input  wire logic [4:0]  bus_out,
   input  wire logic [4:0]  bus_oe,
   output logic             us_in,
   output logic      [4:0]  bus_in
);
   logic [15:0] ph;
   // A silent amplifier rests low; a tone is a square wave of tone_per clocks.
   always @(posedge pclk) begin
      if (tone_per == 16'h0000) begin
         ph <= 16'h0000;
         us_in <= 1'b0;
      end else begin
         ph <= (ph + 16'h0001 >= tone_per) ? 16'h0000 : ph + 16'h0001;
         us_in <= (ph < tone_per / 2);
      end
   end
   // The pull keeps a free line low; the device's driver beats a pressed key.
   always_comb bus_in = (bus_oe & bus_out) | (~bus_oe & key);
endmodule // ucr_partner

// >>> bench/ucr_receiver_tb.sv
`timescale 1ns/100ps
module ucr_receiver_tb;
   localparam int SETTLE = 3000;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, us_in, power_on, rerr;
   logic        clr_l;
   wire  [2:0]  pw;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [4:0]  bus_in, bus_out, bus_oe, key, last_q, c;
   logic [4:0]  lv [3];
   logic [15:0] per;
   int          n_errors, n_compared, s, j;

   ucr_receiver #(.SETTLE_CYC(SETTLE), .MEAS_CYC(SETTLE), .HOLD_CYC(1200), .PROC_CYC(300),
      .PULSE_CYC(200), .STEP_CYC(150), .PWM_DIV(2)) dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .us_in(us_in), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
      .power_on(power_on), .vol_pwm(pw[0]), .color_pwm(pw[1]), .bright_pwm(pw[2]));
   ucr_partner u_far (.pclk(pclk), .tone_per(per), .key(key), .bus_out(bus_out),
      .bus_oe(bus_oe), .us_in(us_in), .bus_in(bus_in));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) last_q <= (|bus_oe) ? bus_oe : (clr_l ? 5'h00 : last_q);

   function automatic logic [31:0] lvexp();
      return {11'h000, lv[2], 3'h0, lv[1], 3'h0, lv[0]};
   endfunction
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task chk_pwm();
      int h [3];
      h = '{0, 0, 0};
      repeat (60) begin
         @(posedge pclk);
         foreach (h[i]) h[i] += int'(pw[i]);
      end
      foreach (h[i]) chk("pwm", 2 * lv[i], h[i]);
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task press(input logic [4:0] k, input int h);
      clr_l <= 1'b1;
      key <= k;
      @(posedge pclk);
      clr_l <= 1'b0;
      repeat (h - 1) @(posedge pclk);
      key <= 5'h00;
      repeat (700) @(posedge pclk);
      chk("pulse", {27'h0, k}, {27'h0, last_q});
   endtask
   task step(input logic [4:0] k, input int h, input logic on);
      press(k, h);
      apb(1'b0, 8'h04, 32'h0);
      chk("power", {31'h0, on}, {31'h0, rdat[0]});
      chk("power_on", {31'h0, on}, {31'h0, power_on});
   endtask
   task print_verdict();
      if (n_errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (95000) @(posedge pclk);
      n_errors++;
      print_verdict();
   end

   initial begin
      {n_errors, n_compared} = 0;
      {presetn, psel, penable, pwrite, paddr, pwdata, key, per, clr_l} = 0;
      lv = '{5'h0F, 5'h0F, 5'h0F};
      s = int'($urandom(15183) % 6);
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl", 32'h1, rdat);
      apb(1'b0, 8'h04, 32'h0);
      chk("status", 32'h0, rdat & 32'h83);
      apb(1'b0, 8'h08, 32'h0);
      chk("levels", lvexp(), rdat);
      apb(1'b0, 8'h0C, 32'h0);
      chk("unmapped", 32'h1, {31'h0, rerr});
      step(5'h10, 1900, 1'b1);
      for (int i = 0; i < 6; i++) begin
         j = (i + s) % 6;
         press(5'(4 + 2 * j), 4800 + int'($urandom % 100));
         lv[j < 2 ? 1 : (j < 4 ? 2 : 0)] = j[0] ? 5'h01 : 5'h1E;
         apb(1'b0, 8'h08, 32'h0);
         chk("levels", lvexp(), rdat);
         chk_pwm();
      end
      press(5'h03, 900);
      c = (lv[0] == 5'h1E) ? 5'h0E : 5'h0C;
      press(c, 1500);
      apb(1'b0, 8'h04, 32'h0);
      chk("muted", 32'h1, {31'h0, rdat[1]});
      apb(1'b0, 8'h08, 32'h0);
      chk("levels", lvexp(), rdat);
      press(5'h05, 900);
      lv = '{5'h0F, 5'h0F, 5'h0F};
      apb(1'b0, 8'h04, 32'h0);
      chk("muted", 32'h0, {31'h0, rdat[1]});
      apb(1'b0, 8'h08, 32'h0);
      chk("levels", lvexp(), rdat);
      step(5'h02, 600, 1'b1);
      step(5'h02, 1900, 1'b0);
      press(5'h04, 1500);
      apb(1'b0, 8'h08, 32'h0);
      chk("levels", lvexp(), rdat);
      step(5'h02, 1900, 1'b1);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl", 32'h0, rdat);
      step(5'h02, 1900, 1'b0);
      step(5'h02, 1900, 1'b0);
      per <= 16'(460 + $urandom % 430);
      repeat (SETTLE + 2200) @(posedge pclk);
      // The tone stops while the key is still down so that the remote channel
      // has gone before the local one does and cannot start a second pulse.
      fork
         press(5'h14, 1900);
         begin
            repeat (1000) @(posedge pclk);
            per <= 16'h0000;
         end
      join
      per <= 16'h0000;
      repeat (1200) @(posedge pclk);
      clr_l <= 1'b1;
      per <= 16'(100 + $urandom % 340);
      @(posedge pclk);
      clr_l <= 1'b0;
      repeat (2 * SETTLE + 1000) @(posedge pclk);
      apb(1'b0, 8'h04, 32'h0);
      chk("channel", 32'h0, rdat & 32'h7C);
      per <= 16'h0000;
      repeat (1200) @(posedge pclk);
      chk("pulse", 32'h0, {27'h0, last_q});
      per <= 16'h02BC;
      repeat (1000) @(posedge pclk);
      apb(1'b0, 8'h04, 32'h0);
      chk("rx", 32'h1, {31'h0, rdat[7]});
      per <= 16'h0000;
      repeat (1200) @(posedge pclk);
      apb(1'b0, 8'h04, 32'h0);
      chk("rx", 32'h0, {31'h0, rdat[7]});
      print_verdict();
   end
endmodule // ucr_receiver_tb

bind ucr_receiver ucr_receiver_sva #(.PROC_CYC(PROC_CYC), .PULSE_CYC(PULSE_CYC)) u_sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .bus_out(bus_out), .bus_oe(bus_oe), .power_on(power_on));
